// *** design/srf_pkg.sv ***
package srf_pkg;
  localparam int FRAME_BYTES = 3;
  localparam logic [2:0] RSP_LEN_READ = 3'h3;
  localparam logic [2:0] RSP_LEN_RAW = 3'h4;
  localparam logic [2:0] RSP_LEN_FULL = 3'h7;
  localparam logic [2:0] RSP_LEN_NONE = 3'h1;
  localparam int RESULT_BITS = 24;
  localparam logic [4:0] RESULT_BITS_5 = 5'h18;
  // command byte layout
  localparam logic [3:0] RAW_NIB = 4'hA;
  localparam logic [1:0] READ_OP = 2'h0;
  localparam logic [1:0] WRITE_OP = 2'h1;
  localparam logic [7:0] CMD_FULL = 8'hAA;
  localparam logic [7:0] CMD_CHECKSUM = 8'h90;
  localparam logic [7:0] CMD_SEL_SETUP1 = 8'hB0;
  localparam logic [7:0] CMD_SEL_SETUP2 = 8'hB1;
  localparam int TYPE_EXT_CFG = 0;
  localparam int TYPE_AUTOZERO = 1;
  localparam int TYPE_TEMP = 2;
  localparam int TYPE_RESERVED = 3;
  // nonvolatile memory map
  localparam int NVM_WORDS = 64;
  localparam int NVM_AW = 6;
  localparam logic [5:0] USER_WORDS = 6'h1A;
  localparam logic [5:0] CHECKSUM_ADDR = 6'h39;
  localparam logic [5:0] SETUP1_ADDR = 6'h02;
  localparam logic [5:0] SETUP2_ADDR = 6'h03;
  // status byte
  localparam logic [7:0] STAT_POWER = 8'h40;
  localparam logic [7:0] STAT_BUSY = 8'h20;
  localparam logic [7:0] STAT_MEMERR = 8'h04;
  typedef enum logic [1:0] {DEV_IDLE, DEV_SCAN, DEV_MEAS} srf_dev_state_e;
  typedef enum logic [2:0] {HST_IDLE, HST_SEND, HST_GUARD, HST_WAIT, HST_READ, HST_DONE}
    srf_host_state_e;
endpackage : srf_pkg

// *** design/srf_link_if.sv ***
`timescale 1ns/1ns
interface srf_link_if;
  logic cmd_valid;
  logic [7:0] cmd_data;
  logic rsp_req;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic dev_busy;
  modport dev (input cmd_valid, input cmd_data, input rsp_req,
               output rsp_valid, output rsp_data, output dev_busy);
  modport host (output cmd_valid, output cmd_data, output rsp_req,
                input rsp_valid, input rsp_data, input dev_busy);
endinterface : srf_link_if

// *** design/srf_device.sv ***
// Operation
// - every command frame is three bytes
// - responses are one, three, four or seven bytes
// - results are 24-bit, MSB byte first
// - host shifts short results right arithmetically
// - raw command is A nibble plus type
// - eight raw types: zero, input, config source
// - memory is 16-bit words, 0x1A user
// - checksum word at 0x39 written on request
// - memory error clears at power-up after checksum
// - host writes checksum as last step
// - types 0, 2, 4 and 6 use stored setup
// - selected setup holds until the next select command or reset; first default
// - measurement response starts with status byte
`timescale 1ns/1ns
module srf_device #(
  parameter int NVM_WORDS = srf_pkg::NVM_WORDS
) (
  input wire logic ref_clk, // system clock
  input wire logic rst, // synchronous reset, power-up
  srf_link_if.dev link, // byte link to host
  output logic meas_start, // pulse: start conversion
  output logic [15:0] meas_cfg, // setup for the conversion
  output logic meas_temp, // temperature input chosen
  output logic meas_autozero, // offset measurement chosen
  output logic meas_full, // full measurement, two results
  input wire logic meas_done, // pulse: conversion finished
  input wire logic [23:0] meas_result, // first result
  input wire logic [23:0] meas_result2, // temperature result of full measurement
  output logic mem_error, // checksum mismatch at power-up
  output logic setup2_active // second stored setup in use
);

  ////////////////////////////////////////////////////////////////////////
  srf_pkg::srf_dev_state_e st_q, st_d;
  logic [1:0] byte_cnt_q;
  logic [7:0] op_q;
  logic [7:0] d1_q;
  logic [15:0] nvm_q [NVM_WORDS];
  logic [47:0] rb_q;
  logic [2:0] rsp_len_q;
  logic [2:0] rsp_idx_q;
  logic [5:0] scan_addr_q;
  logic [15:0] scan_sum_q;
  logic scan_wr_q;
  logic mem_error_q;
  logic setup2_q;
  logic meas_start_q;
  logic [15:0] meas_cfg_q;
  logic meas_temp_q;
  logic meas_autozero_q;
  logic meas_full_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic busy_q;

  ////////////////////////////////////////////////////////////////////////
  // frame decode
  wire idle = (st_q == srf_pkg::DEV_IDLE);
  wire last_byte = (byte_cnt_q == 2'(srf_pkg::FRAME_BYTES - 1));
  wire frame_end = idle && link.cmd_valid && last_byte;
  wire [15:0] fdata = {d1_q, link.cmd_data};
  wire [5:0] op_addr = op_q[5:0];
  wire is_read = (op_q[7:6] == srf_pkg::READ_OP);
  wire is_write = (op_q[7:6] == srf_pkg::WRITE_OP);
  wire is_raw = (op_q[7:4] == srf_pkg::RAW_NIB) && !op_q[srf_pkg::TYPE_RESERVED];
  wire is_full = (op_q == srf_pkg::CMD_FULL);
  wire is_cks = (op_q == srf_pkg::CMD_CHECKSUM);
  wire is_sel1 = (op_q == srf_pkg::CMD_SEL_SETUP1);
  wire is_sel2 = (op_q == srf_pkg::CMD_SEL_SETUP2);
  wire raw_ext = op_q[srf_pkg::TYPE_EXT_CFG];
  wire [5:0] setup_addr = setup2_q ? srf_pkg::SETUP2_ADDR : srf_pkg::SETUP1_ADDR;
  wire [15:0] stored_measure_setup = nvm_q[setup_addr];
  wire [15:0] sel_cfg = (is_raw && raw_ext) ? fdata : stored_measure_setup;
  wire user_wr = frame_end && is_write && (op_addr < srf_pkg::USER_WORDS);
  wire [15:0] rd_word = nvm_q[op_addr];

  ////////////////////////////////////////////////////////////////////////
  // checksum scan
  wire [15:0] scan_total = scan_sum_q + nvm_q[scan_addr_q];
  wire scan_last = (scan_addr_q == srf_pkg::CHECKSUM_ADDR - 6'h01);
  wire scan_end = (st_q == srf_pkg::DEV_SCAN) && scan_last;
  wire cks_wr = scan_end && scan_wr_q;
  wire meas_end = (st_q == srf_pkg::DEV_MEAS) && meas_done;

  ////////////////////////////////////////////////////////////////////////
  // response bytes
  wire [7:0] status = srf_pkg::STAT_POWER | (busy_q ? srf_pkg::STAT_BUSY : 8'h00)
                    | (mem_error_q ? srf_pkg::STAT_MEMERR : 8'h00);
  wire [55:0] rsp_all = {status, rb_q};
  wire [5:0] rsp_sel = 6'(55) - {rsp_idx_q, 3'b000};
  wire in_len = (rsp_idx_q < rsp_len_q);
  wire [7:0] rsp_byte = in_len ? rsp_all[rsp_sel -: 8] : 8'h00;
  wire [47:0] meas_bytes = meas_full_q ? {meas_result, meas_result2}
                                       : {meas_result, 24'h000000};

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      srf_pkg::DEV_IDLE: begin
        if (frame_end && (is_raw || is_full)) begin
          st_d = srf_pkg::DEV_MEAS;
        end else if (frame_end && is_cks) begin
          st_d = srf_pkg::DEV_SCAN;
        end
      end
      srf_pkg::DEV_SCAN: begin
        if (scan_last) begin
          st_d = srf_pkg::DEV_IDLE;
        end
      end
      srf_pkg::DEV_MEAS: begin
        if (meas_done) begin
          st_d = srf_pkg::DEV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= srf_pkg::DEV_SCAN;
      busy_q <= 1'b1;
    end else begin
      st_q <= st_d;
      busy_q <= (st_d != srf_pkg::DEV_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame collection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      byte_cnt_q <= 2'h0;
      op_q <= 8'h00;
      d1_q <= 8'h00;
    end else if (idle && link.cmd_valid) begin
      byte_cnt_q <= last_byte ? 2'h0 : byte_cnt_q + 2'h1;
      if (byte_cnt_q == 2'h0) begin
        op_q <= link.cmd_data;
      end
      if (byte_cnt_q == 2'h1) begin
        d1_q <= link.cmd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // nonvolatile store, kept across reset; comes up erased to zero
  initial begin
    for (int i = 0; i < NVM_WORDS; i++) nvm_q[i] = 16'h0000;
  end
  always @(posedge ref_clk) begin
    if (user_wr) begin
      nvm_q[op_addr] <= fdata;
    end
    if (cks_wr) begin
      nvm_q[srf_pkg::CHECKSUM_ADDR] <= scan_total;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scan_addr_q <= 6'h00;
      scan_sum_q <= 16'h0000;
      scan_wr_q <= 1'b0;
      mem_error_q <= 1'b0;
    end else begin
      if (st_q == srf_pkg::DEV_SCAN) begin
        scan_addr_q <= scan_last ? 6'h00 : scan_addr_q + 6'h01;
        scan_sum_q <= scan_last ? 16'h0000 : scan_total;
      end
      if (frame_end && is_cks) begin
        scan_wr_q <= 1'b1;
      end else if (scan_end) begin
        scan_wr_q <= 1'b0;
      end
      // only the power-up scan judges the memory
      if (scan_end && !scan_wr_q) begin
        mem_error_q <= (scan_total != nvm_q[srf_pkg::CHECKSUM_ADDR]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // setup selection
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      setup2_q <= 1'b0;
    end else if (frame_end && is_sel2) begin
      setup2_q <= 1'b1;
    end else if (frame_end && is_sel1) begin
      setup2_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // measurement request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meas_start_q <= 1'b0;
      meas_cfg_q <= 16'h0000;
      meas_temp_q <= 1'b0;
      meas_autozero_q <= 1'b0;
      meas_full_q <= 1'b0;
    end else begin
      meas_start_q <= frame_end && (is_raw || is_full);
      if (frame_end && (is_raw || is_full)) begin
        meas_cfg_q <= sel_cfg;
        meas_temp_q <= is_raw && op_q[srf_pkg::TYPE_TEMP];
        meas_autozero_q <= is_raw && op_q[srf_pkg::TYPE_AUTOZERO];
        meas_full_q <= is_full;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // response buffer and readout
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rb_q <= 48'h000000000000;
      rsp_len_q <= srf_pkg::RSP_LEN_NONE;
    end else if (frame_end) begin
      if (is_read) begin
        rb_q <= {rd_word, 32'h00000000};
        rsp_len_q <= srf_pkg::RSP_LEN_READ;
      end else if (is_full) begin
        rsp_len_q <= srf_pkg::RSP_LEN_FULL;
      end else if (is_raw) begin
        rsp_len_q <= srf_pkg::RSP_LEN_RAW;
      end else begin
        rsp_len_q <= srf_pkg::RSP_LEN_NONE;
      end
    end else if (meas_end) begin
      rb_q <= meas_bytes;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp_idx_q <= 3'h0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
    end else begin
      rsp_valid_q <= link.rsp_req;
      if (link.rsp_req) begin
        rsp_data_q <= rsp_byte;
      end
      if (frame_end) begin
        rsp_idx_q <= 3'h0;
      end else if (link.rsp_req && !busy_q && in_len) begin
        rsp_idx_q <= rsp_idx_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_data = rsp_data_q;
  assign link.dev_busy = busy_q;
  assign meas_start = meas_start_q;
  assign meas_cfg = meas_cfg_q;
  assign meas_temp = meas_temp_q;
  assign meas_autozero = meas_autozero_q;
  assign meas_full = meas_full_q;
  assign mem_error = mem_error_q;
  assign setup2_active = setup2_q;

endmodule : srf_device

// *** design/srf_host.sv ***
`timescale 1ns/1ns
module srf_host (
  input wire logic ref_clk, // system clock
  input wire logic rst, // synchronous reset
  srf_link_if.host link, // byte link to device
  input wire logic req_valid, // request a transaction
  input wire logic [23:0] req_frame, // three command bytes, first in [23:16]
  input wire logic [2:0] req_rsp_len, // bytes to read back, 0 for none
  input wire logic [4:0] res_bits, // resolution of the first result
  output logic req_ready, // idle, request taken
  output logic rsp_done, // pulse: response complete
  output logic [55:0] rsp_bytes, // response, first byte in [55:48]
  output logic [23:0] rsp_value, // first result, sign-corrected
  output logic nvm_unsealed // memory written since last checksum
);

  ////////////////////////////////////////////////////////////////////////
  srf_pkg::srf_host_state_e st_q;
  logic [23:0] frame_q;
  logic [1:0] sent_q;
  logic [2:0] len_q;
  logic [2:0] req_cnt_q;
  logic [2:0] got_q;
  logic [55:0] rsp_q;
  logic [23:0] value_q;
  logic done_q;
  logic cmd_valid_q;
  logic [7:0] cmd_data_q;
  logic rsp_req_q;
  logic unsealed_q;

  wire take = (st_q == srf_pkg::HST_IDLE) && req_valid;
  wire sending = (st_q == srf_pkg::HST_SEND);
  wire send_last = (sent_q == 2'(srf_pkg::FRAME_BYTES - 1));
  wire [5:0] put_sel = 6'(55) - {got_q, 3'b000};
  wire [4:0] shift_n = srf_pkg::RESULT_BITS_5 - res_bits;
  wire [7:0] op = frame_q[23:16];
  wire [7:0] send_byte = (sent_q == 2'h0) ? frame_q[23:16]
                       : (sent_q == 2'h1) ? frame_q[15:8] : frame_q[7:0];

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= srf_pkg::HST_IDLE;
      sent_q <= 2'h0;
      req_cnt_q <= 3'h0;
      frame_q <= 24'h000000;
      len_q <= 3'h0;
    end else begin
      unique case (st_q)
        srf_pkg::HST_IDLE: begin
          if (req_valid) begin
            frame_q <= req_frame;
            len_q <= req_rsp_len;
            sent_q <= 2'h0;
            st_q <= srf_pkg::HST_SEND;
          end
        end
        srf_pkg::HST_SEND: begin
          sent_q <= sent_q + 2'h1;
          if (send_last) begin
            st_q <= srf_pkg::HST_GUARD;
          end
        end
        srf_pkg::HST_GUARD: st_q <= srf_pkg::HST_WAIT;
        srf_pkg::HST_WAIT: begin
          if (!link.dev_busy) begin
            req_cnt_q <= 3'h0;
            st_q <= (len_q == 3'h0) ? srf_pkg::HST_DONE : srf_pkg::HST_READ;
          end
        end
        srf_pkg::HST_READ: begin
          if (req_cnt_q != len_q) begin
            req_cnt_q <= req_cnt_q + 3'h1;
          end
          if (link.rsp_valid && (got_q + 3'h1 == len_q)) begin
            st_q <= srf_pkg::HST_DONE;
          end
        end
        srf_pkg::HST_DONE: st_q <= srf_pkg::HST_IDLE;
        default: st_q <= srf_pkg::HST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_valid_q <= 1'b0;
      cmd_data_q <= 8'h00;
      rsp_req_q <= 1'b0;
    end else begin
      cmd_valid_q <= sending;
      cmd_data_q <= send_byte;
      rsp_req_q <= (st_q == srf_pkg::HST_READ) && (req_cnt_q != len_q);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      got_q <= 3'h0;
      rsp_q <= 56'h00000000000000;
      value_q <= 24'h000000;
      done_q <= 1'b0;
      unsealed_q <= 1'b0;
    end else begin
      done_q <= (st_q == srf_pkg::HST_DONE);
      if (take) begin
        got_q <= 3'h0;
        rsp_q <= 56'h00000000000000;
      end else if (link.rsp_valid && (st_q == srf_pkg::HST_READ)) begin
        rsp_q[put_sel -: 8] <= link.rsp_data;
        got_q <= got_q + 3'h1;
      end
      if (st_q == srf_pkg::HST_DONE) begin
        value_q <= 24'($signed(rsp_q[47:24]) >>> shift_n);
      end
      if (sending && send_last) begin
        if (op == srf_pkg::CMD_CHECKSUM) begin
          unsealed_q <= 1'b0;
        end else if (op[7:6] == srf_pkg::WRITE_OP) begin
          unsealed_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign link.cmd_valid = cmd_valid_q;
  assign link.cmd_data = cmd_data_q;
  assign link.rsp_req = rsp_req_q;
  assign req_ready = (st_q == srf_pkg::HST_IDLE);
  assign rsp_done = done_q;
  assign rsp_bytes = rsp_q;
  assign rsp_value = value_q;
  assign nvm_unsealed = unsealed_q;

endmodule : srf_host

// *** dv/srf_link_checker.sv ***
`timescale 1ns/1ns
module srf_link_checker (
  input wire logic ref_clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic cmd_valid, // command byte strobe
  input wire logic [7:0] cmd_data, // command byte
  input wire logic rsp_req, // response byte request
  input wire logic rsp_valid, // response byte strobe
  input wire logic [7:0] rsp_data, // response byte
  input wire logic dev_busy // device busy level
);
  logic [1:0] byte_idx_q;
  logic [1:0] byte_idx_d;
  logic [7:0] first_q;
  logic pend_q;
  wire logic taken = cmd_valid && !dev_busy;
  wire logic frame_end = taken && (byte_idx_q == 2'h2);
  wire logic raw_cmd = (first_q[7:4] == srf_pkg::RAW_NIB) && !first_q[3];
  wire logic busy_cmd = raw_cmd || (first_q == srf_pkg::CMD_FULL)
    || (first_q == srf_pkg::CMD_CHECKSUM);

  assign byte_idx_d = frame_end ? 2'h0 : (taken ? byte_idx_q + 2'h1 : byte_idx_q);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      byte_idx_q <= 2'h0;
      first_q <= 8'h00;
      pend_q <= 1'b0;
    end else begin
      byte_idx_q <= byte_idx_d;
      if (taken && byte_idx_q == 2'h0) begin
        first_q <= cmd_data;
      end
      pend_q <= frame_end | (pend_q & ~rsp_valid);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_frame_start;
    taken && (byte_idx_q == 2'h0);
  endsequence
  sequence s_frame_end;
    frame_end;
  endsequence

  a_rsp_follows_req: assert property (rsp_req |=> rsp_valid)
    else $error("response byte did not follow request");
  a_no_stray_valid: assert property (rsp_valid |-> $past(rsp_req))
    else $error("response byte without request");
  a_rsp_data_holds: assert property (!$past(rsp_req) |-> $stable(rsp_data))
    else $error("response byte changed without request");
  a_scan_after_reset: assert property ($fell(rst) |-> dev_busy [*8])
    else $error("busy not held during power-up scan");
  a_frame_back_to_back: assert property (s_frame_start |=> cmd_valid [*2])
    else $error("command frame not three contiguous bytes");
  a_busy_at_frame_end: assert property (s_frame_end ##0 busy_cmd |=> dev_busy)
    else $error("busy not raised after measurement frame");
  a_idle_mid_frame: assert property (taken && byte_idx_q != 2'h2 |=> !dev_busy)
    else $error("busy raised before third byte");
  a_status_first: assert property (rsp_valid && pend_q |->
    rsp_data[6] && ((rsp_data & 8'h9B) == 8'h00))
    else $error("first response byte is not status");
  a_no_cmd_when_busy: assert property (cmd_valid |-> !dev_busy)
    else $error("command byte sent while busy");
endmodule : srf_link_checker

// *** dv/sensor_raw_command_frontend_tb_top.sv ***
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("[ERR] %s exp %0h got %0h", n, e, g); err_total++; end end
module sensor_raw_command_frontend_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic [23:0] req_frame = 24'h000000;
  logic [2:0] req_rsp_len = 3'h0;
  logic [4:0] res_bits = 5'h18;
  logic meas_done = 1'b0;
  logic [23:0] res1 = 24'hD99180;
  logic [23:0] res2 = 24'h72C56F;
  logic req_ready, rsp_done, nvm_unsealed, meas_start, meas_temp, meas_autozero;
  logic meas_full, mem_error, setup2_active;
  logic [55:0] rsp_bytes;
  logic [23:0] rsp_value;
  logic [15:0] meas_cfg;
  logic [15:0] cap_cfg = 16'h0000;
  logic [2:0] cap_mode = 3'h0;
  logic [3:0] dly_q = 4'h0;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;

  srf_link_if link ();
  srf_device u_srf_device (.ref_clk(ref_clk), .rst(rst), .link(link),
    .meas_start(meas_start), .meas_cfg(meas_cfg), .meas_temp(meas_temp),
    .meas_autozero(meas_autozero), .meas_full(meas_full), .meas_done(meas_done),
    .meas_result(res1), .meas_result2(res2), .mem_error(mem_error),
    .setup2_active(setup2_active));
  srf_host u_srf_host (.ref_clk(ref_clk), .rst(rst), .link(link), .req_valid(req_valid),
    .req_frame(req_frame), .req_rsp_len(req_rsp_len), .res_bits(res_bits),
    .req_ready(req_ready), .rsp_done(rsp_done), .rsp_bytes(rsp_bytes),
    .rsp_value(rsp_value), .nvm_unsealed(nvm_unsealed));
  srf_link_checker u_srf_link_checker (.ref_clk(ref_clk), .rst(rst),
    .cmd_valid(link.cmd_valid), .cmd_data(link.cmd_data), .rsp_req(link.rsp_req),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data), .dev_busy(link.dev_busy));

  always #5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // conversion stand-in: done five cycles after start
  always @(posedge ref_clk) begin
    meas_done <= (dly_q == 4'h1);
    if (meas_start === 1'b1) begin
      dly_q <= 4'h5;
      cap_cfg <= meas_cfg;
      cap_mode <= {meas_full, meas_temp, meas_autozero};
    end else if (dly_q != 4'h0) begin
      dly_q <= dly_q - 4'h1;
    end
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic do_req(input logic [23:0] f, input logic [2:0] n, input logic [4:0] b);
    int k;
    @(posedge ref_clk);
    for (k = 0; k < 500 && !(link.dev_busy === 1'b0 && req_ready === 1'b1); k++) begin
      @(posedge ref_clk);
    end
    req_valid <= 1'b1;
    req_frame <= f;
    req_rsp_len <= n;
    res_bits <= b;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    for (k = 0; k < 500 && rsp_done !== 1'b1; k++) begin
      @(negedge ref_clk);
    end
    `CHK("rsp_done", 1'b1, rsp_done)
    `CHK("status", 8'h40, rsp_bytes[55:48] & 8'hFB)
    `CHK("tail", 56'h0, rsp_bytes << (8 * n))
  endtask : do_req

  task automatic pulse_rst();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
  endtask : pulse_rst

  task automatic t_mem();
    do_req({8'h42, 16'h1357}, 3'h1, 5'h18);
    do_req({8'h43, 16'h2468}, 3'h1, 5'h18);
    do_req({8'h59, 16'hABCD}, 3'h1, 5'h18);
    `CHK("unsealed", 1'b1, nvm_unsealed)
    `CHK("memerr0", 1'b0, mem_error)
    do_req({8'h02, 16'h0000}, 3'h3, 5'h18);
    `CHK("word02", 16'h1357, rsp_bytes[47:32])
    do_req({8'h19, 16'h0000}, 3'h3, 5'h18);
    `CHK("word19", 16'hABCD, rsp_bytes[47:32])
    do_req({srf_pkg::CMD_CHECKSUM, 16'h0000}, 3'h1, 5'h18);
    `CHK("sealed", 1'b0, nvm_unsealed)
    do_req({8'h39, 16'h0000}, 3'h3, 5'h18);
    `CHK("cksword", 16'hE38C, rsp_bytes[47:32])
    do_req({8'h59, 16'hABCE}, 3'h1, 5'h18);
    pulse_rst();
    do_req({srf_pkg::CMD_CHECKSUM, 16'h0000}, 3'h1, 5'h18);
    `CHK("memerr1", 1'b1, mem_error)
  endtask : t_mem

  task automatic t_raw_all();
    for (int t = 0; t < 8; t++) begin
      @(posedge ref_clk);
      res1 <= t[0] ? 24'h72C56F : 24'hD99180;
      do_req({4'hA, t[3:0], 16'h0225}, 3'h4, 5'(24 - t));
      `CHK("cfg", t[0] ? 16'h0225 : 16'h1357, cap_cfg)
      `CHK("mode", {1'b0, t[2], t[1]}, cap_mode)
      `CHK("result", res1, rsp_bytes[47:24])
      `CHK("value", 24'($signed(res1) >>> t), rsp_value)
    end
  endtask : t_raw_all

  task automatic t_full();
    @(posedge ref_clk);
    res1 <= 24'h72C56F;
    res2 <= 24'hD99180;
    do_req({srf_pkg::CMD_FULL, 16'h0000}, 3'h7, 5'h18);
    `CHK("full", 1'b1, cap_mode[2])
    `CHK("sensor", 24'h72C56F, rsp_bytes[47:24])
    `CHK("temp", 24'hD99180, rsp_bytes[23:0])
    `CHK("fvalue", 24'h72C56F, rsp_value)
  endtask : t_full

  task automatic t_setup();
    do_req({srf_pkg::CMD_SEL_SETUP2, 16'h0000}, 3'h1, 5'h18);
    `CHK("sel2", 1'b1, setup2_active)
    do_req({8'hA2, 16'h0225}, 3'h4, 5'h18);
    `CHK("cfg2", 16'h2468, cap_cfg)
    do_req({srf_pkg::CMD_SEL_SETUP1, 16'h0000}, 3'h1, 5'h18);
    `CHK("sel1", 1'b0, setup2_active)
    do_req({8'hA0, 16'h0225}, 3'h4, 5'h18);
    `CHK("cfg1", 16'h1357, cap_cfg)
    do_req({srf_pkg::CMD_SEL_SETUP2, 16'h0000}, 3'h1, 5'h18);
    pulse_rst();
    @(negedge ref_clk);
    `CHK("selrst", 1'b0, setup2_active)
    do_req({8'hA6, 16'h0225}, 3'h4, 5'h18);
    `CHK("cfgrst", 16'h1357, cap_cfg)
    `CHK("memerr2", 1'b0, mem_error)
  endtask : t_setup

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_mem();
    t_raw_all();
    t_full();
    t_setup();
    complete_run();
  end
endmodule : sensor_raw_command_frontend_tb_top
